/* common/exc_vec_map.svh */
// Purpose: offsets, field positions, reset values and vector numbers of the exception unit
// Assumes: 32-bit AXI4-Lite register window, one register per aligned word
// Notes:   definitions only
`ifndef EXC_VEC_MAP_SVH
`define EXC_VEC_MAP_SVH
`define OFF_CPS      12'h000
`define OFF_OPS      12'h004
`define OFF_CFG      12'h008
`define OFF_VAB      12'h00c
`define OFF_VINFO    12'h010
`define CPS_GDIS     0
`define CPS_XDIS     1
`define CPS_LVL_LO   2
`define CPS_LVL_HI   3
`define CPS_WAIT     4
`define CPS_ROMF     5
`define CPS_PEND     6
`define CPS_RST      7'h03
`define CFG_VFON     0
`define CFG_ROMV     1
`define CFG_RST      2'h0
`define VAB_RST      32'h0000_0000
`define VEC_FAULT0   8'h0c
`define VEC_FAULT1   8'h0d
`define VEC_TIMER    8'h0e
`define VEC_IRQ0     8'h10
`define VEC_INSN_MIN 8'h40
`define VENT_R_BIT   0
`define WIDTH_WORD   3'h0
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

/* common/exc_vec_pkg.sv */
// Purpose: types shared by the exception unit and its bench
// Assumes: field order matches the bit positions of the map header
// Notes:   cps_s packs with global_mask_bit at bit 0
package exc_vec_pkg;
    typedef enum {
        ST_RUN,
        ST_DRAIN,
        ST_VFETCH,
        ST_GO
    } state_e;

    typedef struct packed {
        logic       pending;
        logic       rom_fetch_flag;
        logic       wait_flag;
        logic [1:0] ext_int_mask_level;
        logic       ext_int_block;
        logic       global_mask_bit;
    } cps_s;

    typedef struct packed {
        logic [31:0] addr;
        logic [2:0]  access_width_code;
        logic        data_access;
    } vec_rd_s;
endpackage

/* src/exc_vector_unit.sv */
// Purpose: interrupt and trap recognition, masking, wait mode and handler vectoring
// Assumes: core signals on aclk; irq and fault pins asynchronous; AXI4-Lite register access
// Notes:   one entry at a time; vector read over a simple valid/ack port
// Functional notes
// - accept interrupts from four external request lines and the timer, asynchronous
// - global disable bit refuses all interrupts and most traps
// - external disable bit blocks external lines only; timer and traps unaffected
// - two-bit mask level: 00 enables line zero, 11 enables all four
// - mask level never disables line zero
// - no external interrupt taken while either disable bit is one
// - pending flag set while any external line active but blocked
// - traps come from two fault lines and internal exception conditions
// - global disable suppresses traps except access and coprocessor exceptions
// - while wait flag set, no fetch, no execution, no bus access
// - wait ends only by taking an enabled interrupt or trap; here a register write to the status word also sets or clears the wait flag
// - vector area holds up to 256 handlers, 8-bit numbers
// - vector fetch: table entry holds word address and location bit
// - no vector fetch: rom-vector bit chooses data memory or ROM
// - no vector fetch: one 64-instruction aligned block per handler; base bits 7 to 0 are kept here, so blocks align only when they are zero
// - taking an event derives an eight-bit vector number
// - vector fetch: number replaces bits 9 to 2 of base
// - no vector fetch: number replaces bits 15 to 8 of base
// - numbers 64 to 255 come from trapping instructions themselves
// - vector read is a data access with full-word width code
// - on entry copy location bit or rom-vector bit into rom-fetch flag
// - on entry copy current status into old status first
// - finish pending load or store, cancel rest of multiple transfer
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "exc_vec_map.svh"
module exc_vector_unit #(
    parameter int ADDR_W = 12
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [ADDR_W-1:0]      awaddr,
    input  wire logic                   awvalid,
    output logic                        awready,
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    input  wire logic                   wvalid,
    output logic                        wready,
    output logic [1:0]                  bresp,
    output logic                        bvalid,
    input  wire logic                   bready,
    input  wire logic [ADDR_W-1:0]      araddr,
    input  wire logic                   arvalid,
    output logic                        arready,
    output logic [31:0]                 rdata,
    output logic [1:0]                  rresp,
    output logic                        rvalid,
    input  wire logic                   rready,
    input  wire logic [3:0]             ext_irq_lines,
    input  wire logic                   timer_irq,
    input  wire logic [1:0]             ext_fault_lines,
    input  wire logic                   exc_valid,
    input  wire logic [7:0]             exc_vector,
    input  wire logic                   exc_nomask,
    output logic                        exc_ack,
    input  wire logic                   ls_busy,
    output logic                        ls_cancel_multi,
    output logic                        fetch_hold,
    output exc_vec_pkg::vec_rd_s        vec_rd,
    output logic                        vec_rd_valid,
    input  wire logic                   vec_rd_ack,
    input  wire logic [31:0]            vec_rd_data,
    output logic                        handler_go,
    output logic [31:0]                 handler_addr,
    output logic [7:0]                  handler_vector
);
    function automatic logic [3:0] level_mask(input logic [1:0] lvl);
        case (lvl)
            2'h0: level_mask = 4'h1;
            2'h1: level_mask = 4'h3;
            2'h2: level_mask = 4'h7;
            default: level_mask = 4'hf;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    exc_vec_pkg::state_e  state_r, state_nxt;
    exc_vec_pkg::cps_s    cps_r, cps_nxt, ops_r, ops_nxt;
    exc_vec_pkg::vec_rd_s vec_rd_r;
    logic [1:0]           cfg_r;
    logic [31:0]          vab_r, handler_addr_r;
    logic [7:0]           vec_num_r;
    logic [3:0]           irq_m_r, irq_s_r;
    logic [1:0]           flt_m_r, flt_s_r;
    logic                 aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
    logic [ADDR_W-1:0]    awaddr_r;
    logic [31:0]          wdata_r, rdata_r;
    logic [3:0]           wstrb_r;
    logic [1:0]           bresp_r, rresp_r;

    // pins cross in through two flops; only the second stage is looked at
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_m_r <= 4'h0;
            irq_s_r <= 4'h0;
            flt_m_r <= 2'h0;
            flt_s_r <= 2'h0;
        end else begin
            irq_m_r <= ext_irq_lines;
            irq_s_r <= irq_m_r;
            flt_m_r <= ext_fault_lines;
            flt_s_r <= flt_m_r;
        end
    end

    wire       gdis     = cps_r.global_mask_bit;
    wire       xdis     = cps_r.ext_int_block;
    wire       vfon     = cfg_r[`CFG_VFON];
    wire       romv     = cfg_r[`CFG_ROMV];
    wire [3:0] lvl_en   = level_mask(cps_r.ext_int_mask_level);
    wire [3:0] irq_live = irq_s_r & lvl_en & {4{!gdis && !xdis}};
    wire       pend_w   = |(irq_s_r & ~irq_live);
    wire       tmr_live = timer_irq && !gdis;
    wire [1:0] flt_live = flt_s_r & {2{!gdis}};
    wire       exc_live = exc_valid && (exc_nomask || !gdis);
    wire       run      = state_r == exc_vec_pkg::ST_RUN;
    wire       take     = run && (exc_live || (|flt_live) || tmr_live || (|irq_live));
    wire [1:0] irq_idx  = irq_live[0] ? 2'h0 : irq_live[1] ? 2'h1 : irq_live[2] ? 2'h2 : 2'h3;
    // priority: internal exception, fault lines, timer, then lowest irq line
    wire [7:0] vec_sel  = exc_live ? exc_vector :
                          (|flt_live) ? (flt_live[0] ? `VEC_FAULT0 : `VEC_FAULT1) :
                          tmr_live ? `VEC_TIMER : `VEC_IRQ0 + {6'h0, irq_idx};
    wire       enter    = state_r == exc_vec_pkg::ST_DRAIN && !ls_busy;
    wire       vec_done = state_r == exc_vec_pkg::ST_VFETCH && vec_rd_ack;
    wire [31:0] tab_addr = {vab_r[31:10], vec_num_r, vab_r[1:0]};
    wire [31:0] blk_addr = {vab_r[31:16], vec_num_r, vab_r[7:0]};

    assign exc_ack         = take && exc_live;
    assign ls_cancel_multi = state_r == exc_vec_pkg::ST_DRAIN;
    assign fetch_hold      = cps_r.wait_flag || !run;
    assign vec_rd_valid    = state_r == exc_vec_pkg::ST_VFETCH;
    assign vec_rd          = vec_rd_r;
    assign handler_go      = state_r == exc_vec_pkg::ST_GO;
    assign handler_addr    = handler_addr_r;
    assign handler_vector  = vec_num_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            exc_vec_pkg::ST_RUN:    if (take) state_nxt = exc_vec_pkg::ST_DRAIN;
            exc_vec_pkg::ST_DRAIN:  if (enter) state_nxt = vfon ? exc_vec_pkg::ST_VFETCH : exc_vec_pkg::ST_GO;
            exc_vec_pkg::ST_VFETCH: if (vec_rd_ack) state_nxt = exc_vec_pkg::ST_GO;
            default:                state_nxt = exc_vec_pkg::ST_RUN;
        endcase
    end

    // register write decode
    wire        do_wr  = aw_hold_r && w_hold_r && !bvalid_r;
    wire [11:0] woff   = 12'(awaddr_r);
    wire        wr_cps = do_wr && woff == `OFF_CPS;
    wire        wr_ops = do_wr && woff == `OFF_OPS;
    wire        wr_cfg = do_wr && woff == `OFF_CFG;
    wire        wr_vab = do_wr && woff == `OFF_VAB;
    wire        wr_ok  = wr_cps || wr_ops || wr_cfg || wr_vab || woff == `OFF_VINFO;
    wire [31:0] mg_cps = merge({25'h0, cps_r}, wdata_r, wstrb_r);
    wire [31:0] mg_ops = merge({25'h0, ops_r}, wdata_r, wstrb_r);
    wire [31:0] mg_cfg = merge({30'h0, cfg_r}, wdata_r, wstrb_r);
    wire [31:0] mg_vab = merge(vab_r, wdata_r, wstrb_r);

    // hardware entry overrides a same-cycle software write, except its mask level and, under vector fetch, its rom-fetch flag
    always_comb begin
        cps_nxt = cps_r;
        ops_nxt = ops_r;
        if (wr_cps) begin
            cps_nxt.global_mask_bit    = mg_cps[`CPS_GDIS];
            cps_nxt.ext_int_block      = mg_cps[`CPS_XDIS];
            cps_nxt.ext_int_mask_level = mg_cps[`CPS_LVL_HI:`CPS_LVL_LO];
            cps_nxt.wait_flag          = mg_cps[`CPS_WAIT];
            cps_nxt.rom_fetch_flag     = mg_cps[`CPS_ROMF];
        end
        if (wr_ops) ops_nxt = exc_vec_pkg::cps_s'(mg_ops[6:0]);
        if (enter) begin
            ops_nxt                 = cps_r;
            cps_nxt.global_mask_bit = 1'b1;
            cps_nxt.ext_int_block   = 1'b1;
            cps_nxt.wait_flag       = 1'b0;
            if (!vfon) cps_nxt.rom_fetch_flag = romv;
        end
        if (vec_done) cps_nxt.rom_fetch_flag = vec_rd_data[`VENT_R_BIT];
        cps_nxt.pending = pend_w;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= exc_vec_pkg::ST_RUN;
            cps_r   <= exc_vec_pkg::cps_s'(`CPS_RST);
            ops_r   <= exc_vec_pkg::cps_s'(`CPS_RST);
            cfg_r   <= `CFG_RST;
            vab_r   <= `VAB_RST;
        end else begin
            state_r <= state_nxt;
            cps_r   <= cps_nxt;
            ops_r   <= ops_nxt;
            if (wr_cfg) cfg_r <= mg_cfg[1:0];
            if (wr_vab) vab_r <= mg_vab;
        end
    end

    // table entry is read as a full-word data access
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vec_num_r      <= 8'h00;
            vec_rd_r       <= '0;
            handler_addr_r <= 32'h0000_0000;
        end else begin
            if (take) vec_num_r <= vec_sel;
            if (enter) begin
                vec_rd_r       <= '{addr: tab_addr, access_width_code: `WIDTH_WORD, data_access: 1'b1};
                handler_addr_r <= blk_addr;
            end
            if (vec_done) handler_addr_r <= {vec_rd_data[31:2], 2'h0};
        end
    end

    // axi4-lite slave: address and data latched in either order
    assign awready = !aw_hold_r && !bvalid_r;
    assign wready  = !w_hold_r && !bvalid_r;
    assign bvalid  = bvalid_r;
    assign bresp   = bresp_r;
    assign arready = !rvalid_r;
    assign rvalid  = rvalid_r;
    assign rdata   = rdata_r;
    assign rresp   = rresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `RESP_OKAY;
            awaddr_r  <= '0;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_hold_r <= 1'b1;
                awaddr_r  <= awaddr;
            end
            if (wvalid && wready) begin
                w_hold_r <= 1'b1;
                wdata_r  <= wdata;
                wstrb_r  <= wstrb;
            end
            if (do_wr) begin
                aw_hold_r <= 1'b0;
                w_hold_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    wire [11:0] roff = 12'(araddr);
    logic [31:0] rd_mux;
    logic        rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        case (roff)
            `OFF_CPS:   rd_mux = {25'h0, cps_r};
            `OFF_OPS:   rd_mux = {25'h0, ops_r};
            `OFF_CFG:   rd_mux = {30'h0, cfg_r};
            `OFF_VAB:   rd_mux = vab_r;
            `OFF_VINFO: rd_mux = {24'h0, vec_num_r};
            default: begin
                rd_mux = 32'h0000_0000;
                rd_ok  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_mux;
            rresp_r  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rready) begin
            rvalid_r <= 1'b0;
        end
    end

    property p_pending;
        @(posedge aclk) disable iff (!aresetn) (|(irq_s_r & ~irq_live)) |=> cps_r.pending;
    endproperty
    a_pending: assert property (p_pending) else $error("pending flag missed a blocked line");

    property p_ext_blocked;
        @(posedge aclk) disable iff (!aresetn)
            (run && (gdis || xdis) && !exc_live && flt_live == 2'h0 && !tmr_live) |-> !take;
    endproperty
    a_ext_blocked: assert property (p_ext_blocked) else $error("external irq taken while disabled");

    property p_gdis_refuses;
        @(posedge aclk) disable iff (!aresetn) (gdis && !(exc_valid && exc_nomask)) |-> !take;
    endproperty
    a_gdis_refuses: assert property (p_gdis_refuses) else $error("event taken under global disable");

    property p_timer_xdis;
        @(posedge aclk) disable iff (!aresetn)
            (run && timer_irq && xdis && !gdis && !exc_live && flt_live == 2'h0) |-> take && vec_sel == `VEC_TIMER;
    endproperty
    a_timer_xdis: assert property (p_timer_xdis) else $error("timer blocked by external disable");

    property p_line0;
        @(posedge aclk) disable iff (!aresetn)
            (run && irq_s_r[0] && !gdis && !xdis) |-> take;
    endproperty
    a_line0: assert property (p_line0) else $error("line zero not taken");

    property p_wait_hold;
        @(posedge aclk) disable iff (!aresetn) cps_r.wait_flag |-> fetch_hold;
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("fetch allowed in wait mode");

    property p_entry;
        @(posedge aclk) disable iff (!aresetn)
            enter |=> ops_r == $past(cps_r) && !cps_r.wait_flag && cps_r.global_mask_bit;
    endproperty
    a_entry: assert property (p_entry) else $error("status not saved or wait not cleared");

    property p_cancel;
        @(posedge aclk) disable iff (!aresetn)
            (take ##1 ls_busy) |-> ls_cancel_multi && !handler_go;
    endproperty
    a_cancel: assert property (p_cancel) else $error("vectored before load/store drained");

    property p_block_addr;
        @(posedge aclk) disable iff (!aresetn)
            (enter && !vfon) |=> handler_go && handler_addr[15:8] == vec_num_r && handler_addr[7:0] == vab_r[7:0];
    endproperty
    a_block_addr: assert property (p_block_addr) else $error("block address wrong");

    property p_table_read;
        @(posedge aclk) disable iff (!aresetn)
            vec_rd_valid |-> vec_rd.addr[9:2] == vec_num_r && vec_rd.access_width_code == `WIDTH_WORD;
    endproperty
    a_table_read: assert property (p_table_read) else $error("vector read address or width wrong");
endmodule

/* dv/vec_mem_model.sv */
// Purpose: vector memory on the far side of the vector read port
// Assumes: one read at a time, answered after ack_delay idle cycles
// Notes:   entry word is derived from its address so the bench can predict it
`timescale 1ns/1ps
module vec_mem_model (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire exc_vec_pkg::vec_rd_s vec_rd,
    input  wire logic                 vec_rd_valid,
    input  wire logic [3:0]           ack_delay,
    output logic                      vec_rd_ack,
    output logic [31:0]               vec_rd_data
);
    logic [3:0] cnt_r;

    // entry: word address from addr bits, location bit from addr bit 2
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r       <= 4'h0;
            vec_rd_ack  <= 1'b0;
            vec_rd_data <= 32'h0;
        end else if (vec_rd_valid && !vec_rd_ack && cnt_r == ack_delay) begin
            cnt_r       <= 4'h0;
            vec_rd_ack  <= 1'b1;
            vec_rd_data <= {vec_rd.addr[23:0], 8'h00} | {31'h0, vec_rd.addr[2]};
        end else begin
            // outside the answer the data toggles, so a late sample never looks valid
            vec_rd_ack  <= 1'b0;
            vec_rd_data <= ~vec_rd_data;
            if (vec_rd_valid && !vec_rd_ack) begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
endmodule

/* dv/testbench.sv */
// Purpose: self-checking bench for the exception vector unit
// Assumes: AXI4-Lite register access, vector memory model on the read port
// Notes:   events are dropped after each take since sources are not latched
`timescale 1ns/1ps
`include "exc_vec_map.svh"
module testbench;
    localparam logic [31:0] VAB = 32'h1234_5678;
    logic                 aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic                 awready, wready, bvalid, arready, rvalid, timer_irq, exc_valid;
    logic                 exc_nomask, exc_ack, ls_busy, ls_cancel_multi, fetch_hold;
    logic                 vec_rd_valid, vec_rd_ack, handler_go;
    logic [11:0]          awaddr, araddr;
    logic [31:0]          wdata, rdata, vec_rd_data, handler_addr, rd_val, va;
    logic [1:0]           bresp, rresp, ext_fault_lines;
    logic [3:0]           ext_irq_lines, ack_delay;
    logic [7:0]           exc_vector, handler_vector, v;
    exc_vec_pkg::vec_rd_s vec_rd;
    int                   bad_count, n_tests, lv, k, acks, cycles = 0;

    exc_vector_unit exc_vector_unit_i (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .ext_irq_lines(ext_irq_lines),
        .timer_irq(timer_irq), .ext_fault_lines(ext_fault_lines), .exc_valid(exc_valid),
        .exc_vector(exc_vector), .exc_nomask(exc_nomask), .exc_ack(exc_ack), .ls_busy(ls_busy),
        .ls_cancel_multi(ls_cancel_multi), .fetch_hold(fetch_hold), .vec_rd(vec_rd),
        .vec_rd_valid(vec_rd_valid), .vec_rd_ack(vec_rd_ack), .vec_rd_data(vec_rd_data),
        .handler_go(handler_go), .handler_addr(handler_addr), .handler_vector(handler_vector));

    vec_mem_model vec_mem_model_i (
        .aclk(aclk), .aresetn(aresetn), .vec_rd(vec_rd), .vec_rd_valid(vec_rd_valid),
        .ack_delay(ack_delay), .vec_rd_ack(vec_rd_ack), .vec_rd_data(vec_rd_data));

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    task report_and_stop;
        $display("Checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // a hang anywhere ends here rather than in a silent stall
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            report_and_stop;
        end
    end

    // exc_ack is a one-cycle pulse; count every one of them
    always @(negedge aclk) begin
        if (exc_ack === 1'b1) acks++;
    end

    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, sa, sw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ta && tw)) begin
            @(negedge aclk);
            sa = awvalid && awready;
            sw = wvalid && wready;
            @(posedge aclk);
            if (sa) awvalid <= 1'b0;
            if (sw) wvalid <= 1'b0;
            ta = ta | sa;
            tw = tw | sw;
        end
        do @(negedge aclk); while (bvalid !== 1'b1);
        chk(bresp, er);
        @(posedge aclk);
        bready <= 1'b0;
    endtask

    task rd(input logic [11:0] a, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        rd_val = rdata;
        chk(rresp, er);
        @(posedge aclk);
        rready <= 1'b0;
    endtask

    task rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        rd(a, `RESP_OKAY);
        chk(rd_val & m, e);
    endtask

    // handler_go is a one-cycle pulse, so it is sampled on every falling edge
    task go(input logic e, input logic [7:0] gv, input logic [31:0] ga);
        int i;
        logic seen;
        seen = 1'b0;
        for (i = 0; i < 20 && !seen; i++) begin
            @(negedge aclk);
            if (handler_go === 1'b1) begin
                seen = 1'b1;
                chk(handler_vector, gv);
                chk(handler_addr, ga);
            end
        end
        chk(seen, e);
        @(posedge aclk);
    endtask

    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, timer_irq, exc_valid, exc_nomask, ls_busy} = '0;
        {awaddr, araddr, wdata, ext_fault_lines, ext_irq_lines, ack_delay, exc_vector} = '0;
        bad_count = 0;
        n_tests = 0;
        acks = 0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(`OFF_CPS, 32'hff, 32'h03);
        rchk(`OFF_OPS, 32'hff, 32'h03);
        rchk(`OFF_CFG, 32'hff, 32'h0);
        rchk(`OFF_VAB, 32'hffffffff, 32'h0);
        rd(12'h020, `RESP_SLVERR);
        chk(rd_val, 32'h0);
        wr(12'h020, 32'h1, `RESP_SLVERR);
        wr(`OFF_VAB, VAB, `RESP_OKAY);
        ext_irq_lines <= 4'h1;
        go(1'b0, 8'h0, 32'h0);
        rchk(`OFF_CPS, 32'hff, 32'h43);
        ext_irq_lines <= 4'h0;
        for (lv = 0; lv < 4; lv++) begin
            v = `VEC_IRQ0 + 8'(lv);
            wr(`OFF_CPS, 32'(lv) << 2, `RESP_OKAY);
            if (lv < 3) begin
                ext_irq_lines <= 4'h2 << lv;
                go(1'b0, 8'h0, 32'h0);
                rchk(`OFF_CPS, 32'hff, 32'h40 | (32'(lv) << 2));
            end
            ext_irq_lines <= 4'h1 << lv;
            go(1'b1, v, {VAB[31:16], v, VAB[7:0]});
            ext_irq_lines <= 4'h0;
            rchk(`OFF_OPS, 32'h3f, 32'(lv) << 2);
        end
        rchk(`OFF_CPS, 32'h3f, 32'h0f);
        rchk(`OFF_VINFO, 32'hff, 32'h13);
        wr(`OFF_CPS, 32'h02, `RESP_OKAY);
        ext_irq_lines <= 4'h1;
        go(1'b0, 8'h0, 32'h0);
        timer_irq <= 1'b1;
        go(1'b1, `VEC_TIMER, {VAB[31:16], `VEC_TIMER, VAB[7:0]});
        ext_irq_lines <= 4'h0;
        wr(`OFF_CPS, 32'h01, `RESP_OKAY);
        ext_fault_lines <= 2'b01;
        exc_vector <= 8'h05;
        exc_valid <= 1'b1;
        go(1'b0, 8'h0, 32'h0);
        exc_nomask <= 1'b1;
        go(1'b1, 8'h05, {VAB[31:16], 8'h05, VAB[7:0]});
        chk(acks, 32'h1);
        {exc_valid, exc_nomask, timer_irq} <= 3'b000;
        ext_fault_lines <= 2'b11;
        wr(`OFF_CPS, 32'h0, `RESP_OKAY);
        go(1'b1, `VEC_FAULT0, {VAB[31:16], `VEC_FAULT0, VAB[7:0]});
        ext_fault_lines <= 2'b10;
        wr(`OFF_CPS, 32'h0, `RESP_OKAY);
        go(1'b1, `VEC_FAULT1, {VAB[31:16], `VEC_FAULT1, VAB[7:0]});
        ext_fault_lines <= 2'b00;
        wr(`OFF_CPS, 32'h11, `RESP_OKAY);
        timer_irq <= 1'b1;
        go(1'b0, 8'h0, 32'h0);
        @(negedge aclk);
        chk(fetch_hold, 1'b1);
        rchk(`OFF_CPS, 32'hff, 32'h11);
        wr(`OFF_CPS, 32'h12, `RESP_OKAY);
        go(1'b1, `VEC_TIMER, {VAB[31:16], `VEC_TIMER, VAB[7:0]});
        rchk(`OFF_CPS, 32'h3f, 32'h03);
        timer_irq <= 1'b0;
        wr(`OFF_CFG, 32'h2, `RESP_OKAY);
        wr(`OFF_CPS, 32'h0, `RESP_OKAY);
        ls_busy <= 1'b1;
        timer_irq <= 1'b1;
        go(1'b0, 8'h0, 32'h0);
        @(negedge aclk);
        chk(ls_cancel_multi, 1'b1);
        @(posedge aclk);
        ls_busy <= 1'b0;
        go(1'b1, `VEC_TIMER, {VAB[31:16], `VEC_TIMER, VAB[7:0]});
        timer_irq <= 1'b0;
        rchk(`OFF_CPS, 32'h3f, 32'h23);
        wr(`OFF_CFG, 32'h1, `RESP_OKAY);
        for (k = 0; k < 2; k++) begin
            v = k ? `VEC_INSN_MIN : 8'h41;
            va = {VAB[31:10], v, VAB[1:0]};
            wr(`OFF_CPS, 32'h0, `RESP_OKAY);
            ack_delay <= k ? 4'h0 : 4'h3;
            exc_vector <= v;
            exc_valid <= 1'b1;
            for (lv = 0; lv < 20 && vec_rd_valid !== 1'b1; lv++) @(negedge aclk);
            chk(vec_rd.addr, va);
            chk({vec_rd.access_width_code, vec_rd.data_access}, {`WIDTH_WORD, 1'b1});
            go(1'b1, v, {va[23:0], 8'h00});
            exc_valid <= 1'b0;
            rchk(`OFF_CPS, 32'h3f, {26'h0, v[0], 5'h03});
        end
        chk(acks, 32'h3);
        report_and_stop;
    end
endmodule
